// ### rtl/fspc_flash_ctrl.v
// flash self-programming controller: wishbone registers, key unlock, sequencer
//
// Notes on behaviour
// RULE_01: one 24-bit word per program op; erase its page first.
// RULE_02: key 0x55 then 0xaa, consecutive writes, right before start.
// RULE_03: software waits out operation; two no-ops after start advised.
// RULE_04: erasing last page also clears stored configuration words.
// RULE_05: start bit 15 launches self-timed op; hardware clears when done.
// RULE_06: start bit set-only; writing zero has no effect.
// RULE_07: enable bit 14 permits erase/program; zero inhibits them.
// RULE_08: error bit 13 set on improper start or termination.
// RULE_09: erase-select bit 6 picks erase (1) or program (0).
// RULE_10: erase: 1101 segment, 0010 page; others do nothing.
// RULE_11: program: 0011 programs one word; others do nothing.
// RULE_12: control bits clear only on power-on reset.
// RULE_13: key register write-only, low byte; reads zero.
// RULE_14: control bits 12-7 and 5-4 read zero, ignore writes.
// RULE_15: processor stalled while an operation runs.
// RULE_16: page erase hits whole aligned 512-word page.
// RULE_17: start without key or enable: flash untouched, error set.
`default_nettype none
`include "fspc_regs.vh"
module fspc_flash_ctrl #(
  parameter [31:0] WORD_CYCLES = `FSPC_WORD_CYCLES,
  parameter [31:0] PAGE_CYCLES = `FSPC_PAGE_CYCLES,
  parameter        ADDR_W      = 16,
  parameter [15:0] LAST_PAGE   = 16'h001f
) (
  input  wire              mclk,
  input  wire              reset,
  input  wire              porReset,
  input  wire              wb_cyc_i,
  input  wire              wb_stb_i,
  input  wire              wb_we_i,
  input  wire [3:0]        wb_adr_i,
  input  wire [3:0]        wb_sel_i,
  input  wire [31:0]       wb_dat_i,
  output reg  [31:0]       wb_dat_o,
  output reg               wb_ack_o,
  input  wire [ADDR_W-1:0] targetAddr,
  input  wire              abortOp,
  output wire              cpuStall,
  output reg               flashErasePage,
  output reg               flashEraseSegment,
  output reg               flashProgramWord,
  output reg               flashClearConfig,
  output reg  [ADDR_W-1:0] flashAddr,
  output wire              irq
);
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_RUN  = 2'b10;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire        wbReq    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire        wbWrite  = wbReq && wb_we_i;
  wire        selLo    = wb_sel_i[0];
  wire        selHi    = wb_sel_i[1];
  wire        hitCtrl  = (wb_adr_i == `FSPC_ADDR_CTRL);
  wire        hitKey   = (wb_adr_i == `FSPC_ADDR_KEY);
  wire        hitStat  = (wb_adr_i == `FSPC_ADDR_IRQSTAT);
  wire        hitMask  = (wb_adr_i == `FSPC_ADDR_IRQMASK);

  reg  [1:0]  state_ff;
  reg         start_ff;
  reg         enable_ff;
  reg         seqErr_ff;
  reg         erase_ff;
  reg  [3:0]  opSel_ff;
  wire [1:0]  irqStat;
  wire [1:0]  irqEvent;
  wire [1:0]  irqClear;
  reg  [1:0]  irqMask_ff;
  wire        unlocked;
  wire        timerBusy;
  wire        timerDone;

  // an attempt to set start: a control write with bit 15 high in the upper lane
  wire        startTry = wbWrite && hitCtrl && selHi && wb_dat_i[`FSPC_BIT_START];
  wire        nxtEnable = (wbWrite && hitCtrl && selHi) ? wb_dat_i[`FSPC_BIT_ENABLE]
                                                         : enable_ff;
  wire        startOk  = startTry && unlocked && nxtEnable && (state_ff == ST_IDLE); // see RULE_02
  wire        startBad = startTry && !startOk;                                     // see RULE_17
  wire [3:0]  nxtOp    = (wbWrite && hitCtrl && selLo) ? wb_dat_i[3:0] : opSel_ff;
  wire        nxtErase = (wbWrite && hitCtrl && selLo) ? wb_dat_i[`FSPC_BIT_ERASE] : erase_ff;
  wire        doPage   = nxtErase && (nxtOp == `FSPC_OP_PAGE);     // see RULE_10
  wire        doSeg    = nxtErase && (nxtOp == `FSPC_OP_SEGMENT);  // see RULE_10
  wire        doWord   = !nxtErase && (nxtOp == `FSPC_OP_WORD);    // see RULE_09 RULE_11
  wire        doReal   = doPage || doSeg || doWord;
  // a system reset mid-run empties the timer; treat that as an improper end, not a hang
  wire        timerLost = (state_ff == ST_RUN) && !timerBusy && !timerDone;
  wire        termBad  = ((state_ff == ST_RUN) && abortOp) || timerLost; // see RULE_08
  wire        opEnd    = (state_ff == ST_RUN) && (timerDone || abortOp || timerLost);
  wire [ADDR_W-1:0] pageBase =
    {targetAddr[ADDR_W-1:`FSPC_PAGE_LSB], {`FSPC_PAGE_LSB{1'b0}}}; // see RULE_16
  wire        lastPage = (targetAddr / `FSPC_PAGE_WORDS) == LAST_PAGE;

  ////////////////////////////////////////////////////////////////////////////
  // key tracker and operation timer
  fspc_key_check uKey (
    .mclk     (mclk),
    .reset    (reset),
    .busWrite (wbWrite),
    .keyWrite (hitKey && selLo),
    .keyData  (wb_dat_i[7:0]),
    .consume  (startTry),
    .unlocked (unlocked)
  );

  fspc_op_timer #(
    .WORD_CYCLES (WORD_CYCLES),
    .PAGE_CYCLES (PAGE_CYCLES)
  ) uTimer (
    .mclk   (mclk),
    .reset  (reset),
    .launch (startOk && doReal),
    .longOp (doPage || doSeg),
    .busy   (timerBusy),
    .done   (timerDone)
  );

  ////////////////////////////////////////////////////////////////////////////
  // control register: cleared only by power-on reset, not the system reset
  always @(posedge mclk or posedge porReset) begin
    if (porReset) begin // see RULE_12
      start_ff  <= 1'b0;
      enable_ff <= 1'b0;
      seqErr_ff <= 1'b0;
      erase_ff  <= 1'b0;
      opSel_ff  <= 4'h0;
      state_ff  <= ST_IDLE;
    end else begin
      enable_ff <= nxtEnable;                     // see RULE_07
      erase_ff  <= nxtErase;
      opSel_ff  <= nxtOp;                         // only bits 6,3:0 stored, see RULE_14
      case (state_ff)
        ST_IDLE: begin
          if (startOk && doReal) begin            // see RULE_05 RULE_06
            start_ff <= 1'b1;
            state_ff <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (opEnd) begin                        // hardware alone clears start, see RULE_05
            start_ff <= 1'b0;
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          start_ff <= 1'b0;
          state_ff <= ST_IDLE;
        end
      endcase
      // set wins over a software clear in the same cycle
      if (startBad || termBad) begin              // see RULE_08 RULE_17
        seqErr_ff <= 1'b1;
      end else if (startOk) begin
        seqErr_ff <= 1'b0;
      end else if (wbWrite && hitCtrl && selHi) begin
        seqErr_ff <= wb_dat_i[`FSPC_BIT_SEQERR];
      end
    end
  end

  // no-op codes still count as a clean start: nothing runs, error cleared
  ////////////////////////////////////////////////////////////////////////////
  // flash strobes: one-cycle pulses at launch, page-aligned address for page erase only
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      flashErasePage    <= 1'b0;
      flashEraseSegment <= 1'b0;
      flashProgramWord  <= 1'b0;
      flashClearConfig  <= 1'b0;
      flashAddr         <= {ADDR_W{1'b0}};
    end else begin
      flashErasePage    <= startOk && doPage;               // see RULE_16
      flashEraseSegment <= startOk && doSeg;
      flashProgramWord  <= startOk && doWord;               // see RULE_01
      flashClearConfig  <= startOk && doPage && lastPage;   // see RULE_04
      if (startOk && doReal) begin
        flashAddr <= doPage ? pageBase : targetAddr;
      end
    end
  end

  // cpu held while the sequencer runs; bus stays live so software can poll
  assign cpuStall = (state_ff == ST_RUN) && timerBusy;      // see RULE_15

  ////////////////////////////////////////////////////////////////////////////
  // interrupt events and write-one clears, one bit per event
  assign irqEvent[`FSPC_IRQ_DONE]   = (state_ff == ST_RUN) && timerDone && !abortOp;
  assign irqEvent[`FSPC_IRQ_SEQERR] = startBad || termBad;
  assign irqClear = (wbWrite && hitStat && selLo) ? wb_dat_i[1:0] : 2'b00;

  // sticky status flops; the set term is ORed outside the clear gating so it beats a clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : gIrqBit
      reg stat_ff;
      always @(posedge mclk or posedge reset) begin
        if (reset) begin
          stat_ff <= 1'b0;
        end else begin
          stat_ff <= irqEvent[gi] || (stat_ff && !irqClear[gi]);
        end
      end
      assign irqStat[gi] = stat_ff;
    end
  endgenerate

  // interrupt mask, owned by software
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      irqMask_ff <= 2'b00;
    end else if (wbWrite && hitMask && selLo) begin
      irqMask_ff <= wb_dat_i[1:0];
    end
  end

  assign irq = |(irqStat & irqMask_ff);

  ////////////////////////////////////////////////////////////////////////////
  // read mux and ack: answer one cycle after the request, unmapped reads zero
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wbReq;
      if (wbReq && !wb_we_i) begin
        if (hitCtrl) begin                                  // see RULE_14
          wb_dat_o <= {16'h0, start_ff, enable_ff, seqErr_ff, 6'h00, erase_ff,
                       2'b00, opSel_ff};
        end else if (hitStat) begin
          wb_dat_o <= {30'h0, irqStat};
        end else if (hitMask) begin
          wb_dat_o <= {30'h0, irqMask_ff};
        end else begin
          wb_dat_o <= 32'h0;                                // key reads zero, see RULE_13
        end
      end
    end
  end
endmodule // fspc_flash_ctrl
`default_nettype wire

// ### rtl/fspc_key_check.v
// unlock key pair tracker: arms after 0x55 then 0xaa on consecutive bus writes
`default_nettype none
module fspc_key_check (
  input  wire       mclk,
  input  wire       reset,
  input  wire       busWrite,
  input  wire       keyWrite,
  input  wire [7:0] keyData,
  input  wire       consume,
  output wire       unlocked
);
`include "fspc_regs.vh"
  reg firstSeen_ff;
  reg armed_ff;
  reg nxt_firstSeen;
  reg nxt_armed;

  // any other bus write in between breaks the pair; arming lasts only until next write
  always @* begin
    nxt_firstSeen = firstSeen_ff;
    nxt_armed     = armed_ff;
    if (busWrite) begin
      nxt_firstSeen = keyWrite && (keyData == `FSPC_KEY_FIRST);
      nxt_armed     = keyWrite && firstSeen_ff && (keyData == `FSPC_KEY_SECOND);
    end
    if (consume) begin
      nxt_armed = 1'b0;
    end
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      firstSeen_ff <= 1'b0;
      armed_ff     <= 1'b0;
    end else begin
      firstSeen_ff <= nxt_firstSeen;
      armed_ff     <= nxt_armed;
    end
  end

  assign unlocked = armed_ff;
endmodule // fspc_key_check
`default_nettype wire

// ### rtl/fspc_op_timer.v
// self-timed operation counter; done pulses one cycle when the count runs out
`default_nettype none
`include "fspc_regs.vh"
module fspc_op_timer #(
  parameter [31:0] WORD_CYCLES = `FSPC_WORD_CYCLES,
  parameter [31:0] PAGE_CYCLES = `FSPC_PAGE_CYCLES
) (
  input  wire       mclk,
  input  wire       reset,
  input  wire       launch,
  input  wire       longOp,
  output wire       busy,
  output reg        done
);
  reg [31:0] count_ff;

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      count_ff <= 32'h0;
      done     <= 1'b0;
    end else begin
      done <= (count_ff == 32'h1) && !launch; // a reload must not end the new run
      if (launch) begin
        count_ff <= longOp ? PAGE_CYCLES : WORD_CYCLES;
      end else if (count_ff != 32'h0) begin
        count_ff <= count_ff - 32'h1;
      end
    end
  end

  assign busy = (count_ff != 32'h0);
endmodule // fspc_op_timer
`default_nettype wire

// ### shared/fspc_regs.vh
// register map, field positions, reset values and timing counts of the flash sequencer
`ifndef FSPC_REGS_VH
`define FSPC_REGS_VH
`define FSPC_ADDR_CTRL      4'h0
`define FSPC_ADDR_KEY       4'h4
`define FSPC_ADDR_IRQSTAT   4'h8
`define FSPC_ADDR_IRQMASK   4'hc
`define FSPC_BIT_START      15
`define FSPC_BIT_ENABLE     14
`define FSPC_BIT_SEQERR     13
`define FSPC_BIT_ERASE      6
`define FSPC_CTRL_WMASK     16'h404f
`define FSPC_CTRL_RESET     16'h0000
`define FSPC_KEY_FIRST      8'h55
`define FSPC_KEY_SECOND     8'haa
`define FSPC_OP_SEGMENT     4'hd
`define FSPC_OP_PAGE        4'h2
`define FSPC_OP_WORD        4'h3
`define FSPC_IRQ_DONE       0
`define FSPC_IRQ_SEQERR     1
`define FSPC_WORD_TIME_US   20
`define FSPC_PAGE_TIME_US   40
`define FSPC_CLK_MHZ        50
`define FSPC_WORD_CYCLES    (`FSPC_WORD_TIME_US * `FSPC_CLK_MHZ)
`define FSPC_PAGE_CYCLES    (`FSPC_PAGE_TIME_US * `FSPC_CLK_MHZ)
`define FSPC_PAGE_WORDS     512
`define FSPC_PAGE_LSB       9
`endif

// ### verification/fspc_flash_ctrl_monitor.sv
// port checks for the flash sequencer
`default_nettype none
module fspc_flash_ctrl_monitor #(
  parameter ADDR_W = 16
) (
  input wire logic              mclk,
  input wire logic              reset,
  input wire logic              porReset,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              wb_ack_o,
  input wire logic              cpuStall,
  input wire logic              flashErasePage,
  input wire logic              flashEraseSegment,
  input wire logic              flashProgramWord,
  input wire logic              flashClearConfig,
  input wire logic [ADDR_W-1:0] flashAddr
);
  timeunit 1ns;
  timeprecision 1ns;
  // any operation strobe
  wire anyStrobe = flashErasePage | flashEraseSegment | flashProgramWord;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset || porReset);
  // one-cycle bus answer
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  AST_UPPER_ZERO: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0)
    else $error("upper read half set");
  // strobes only inside a stalled run
  AST_STALL_STROBE: assert property (anyStrobe |-> cpuStall)
    else $error("strobe without stall");
  AST_ONE_KIND: assert property ($onehot0({flashErasePage, flashEraseSegment, flashProgramWord}))
    else $error("two operations at once");
  AST_ONE_WORD: assert property (flashProgramWord |=> !flashProgramWord [*8])
    else $error("second word programmed");
  AST_CFG_PAGE: assert property (flashClearConfig |-> flashErasePage)
    else $error("config cleared without page erase");
  AST_PAGE_ALIGN: assert property (flashErasePage |-> flashAddr[8:0] == 9'h0)
    else $error("page erase not aligned");
  cover property (flashProgramWord);
  cover property (flashEraseSegment);
  cover property (flashClearConfig);
endmodule // fspc_flash_ctrl_monitor
bind fspc_flash_ctrl fspc_flash_ctrl_monitor #(.ADDR_W(ADDR_W)) monU (
  .mclk(mclk), .reset(reset), .porReset(porReset), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpuStall(cpuStall),
  .flashErasePage(flashErasePage), .flashEraseSegment(flashEraseSegment),
  .flashProgramWord(flashProgramWord), .flashClearConfig(flashClearConfig),
  .flashAddr(flashAddr));
`default_nettype wire

// ### verification/tb.sv
// self-checking bench for the flash sequencer
`default_nettype none
`include "fspc_regs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam [3:0] CT = `FSPC_ADDR_CTRL, KY = `FSPC_ADDR_KEY;
  localparam [3:0] ST = `FSPC_ADDR_IRQSTAT, MK = `FSPC_ADDR_IRQMASK;
  logic        mclk, reset, porReset, cyc, stb, we, abortOp;
  logic [3:0]  adr, sel;
  logic [31:0] datI;
  logic [15:0] tgt, ctl, targetAddr, lfsr;
  wire  [31:0] datO;
  wire  [15:0] flashAddr;
  wire         ack, cpuStall, ersPage, ersSeg, progWord, clrCfg, irq;
  logic [31:0] expRd[$], expMsk[$];
  logic [19:0] expSt[$];
  logic [4:0]  good[4] = '{5'h03, 5'h1d, 5'h12, 5'h12};
  logic [4:0]  nop[11] = '{5'h0f, 5'h0d, 5'h0c, 5'h02, 5'h01, 5'h00, 5'h1f, 5'h1c, 5'h13,
                           5'h11, 5'h10};
  int          n_errors, tests_run, cycles;
  // short counts keep the run brief
  fspc_flash_ctrl #(.WORD_CYCLES(16), .PAGE_CYCLES(32)) dut_u (
    .mclk(mclk), .reset(reset), .porReset(porReset), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO),
    .wb_ack_o(ack), .targetAddr(targetAddr), .abortOp(abortOp), .cpuStall(cpuStall),
    .flashErasePage(ersPage), .flashEraseSegment(ersSeg), .flashProgramWord(progWord),
    .flashClearConfig(clrCfg), .flashAddr(flashAddr), .irq(irq));
  always #10 mclk = ~mclk;
  // watchdog for a hung answer or endless stall
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail("timeout");
      end_of_test();
    end
  end
  // watcher: oldest note against each read answer and strobe
  always @(posedge mclk) begin
    if (ack === 1'b1 && we === 1'b0 && expRd.size() > 0)
      cmpRead(datO & expMsk.pop_front(), expRd.pop_front());
    if ((ersPage | ersSeg | progWord | clrCfg) === 1'b1)
      cmpStrobe({clrCfg, ersSeg, ersPage, progWord, flashAddr},
                expSt.size() > 0 ? expSt.pop_front() : 20'h0);
  end
  function automatic logic [15:0] nextRand();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  // clear-config only on the last page
  function automatic logic [19:0] stExp(input logic [4:0] o, input logic [15:0] a);
    if (!o[4]) return {4'b0001, a};
    if (o[3:0] == 4'hd) return {4'b0100, a};
    return {a[15:9] == 7'h1f, 3'b010, a & 16'hfe00};
  endfunction
  task automatic fail(input string m);
    n_errors++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic cmpRead(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) fail("read mismatch");
  endtask
  task automatic cmpStrobe(input logic [19:0] got, input logic [19:0] exp);
    tests_run++;
    if (got !== exp) fail("strobe mismatch");
  endtask
  task automatic cmpIrq(input logic exp);
    @(negedge mclk);
    tests_run++;
    if (irq !== exp) fail("irq mismatch");
  endtask
  // held until ack is sampled, then released
  task automatic bus(input logic w, input logic [3:0] a, input logic [3:0] s,
                     input logic [31:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    datI <= d;
    @(posedge mclk);
    while (ack !== 1'b1) @(posedge mclk);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus(1'b1, a, 4'hf, {16'h0, d});
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m = 16'hffff);
    expRd.push_back({16'h0, e});
    expMsk.push_back({16'hffff, m});
    bus(1'b0, a, 4'hf, 32'h0);
  endtask
  task automatic launch(input logic [15:0] c, input logic key);
    if (key) begin
      wr(KY, 16'h0055);
      wr(KY, 16'h00aa);
    end
    wr(CT, c);
  endtask
  task automatic end_of_test();
    if (n_errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    {mclk, cyc, stb, we, abortOp, adr, sel, datI, targetAddr} = '0;
    {reset, porReset} = 2'b11;
    lfsr = 16'h4632;
    n_errors = 0;
    tests_run = 0;
    cycles = 0;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    porReset <= 1'b0;
    rd(CT, 16'h0);
    rd(KY, 16'h0);
    rd(4'h2, 16'h0);
    tgt = nextRand();
    wr(CT, tgt & 16'h5fff);
    rd(CT, tgt & 16'h404f);
    bus(1'b1, CT, 4'he, 32'h0);
    rd(CT, tgt & 16'h004f);
    wr(MK, 16'h0001);
    foreach (good[i]) begin
      tgt = nextRand();
      if (i == 3) tgt[15:9] = 7'h1f;
      targetAddr <= tgt;
      ctl = {2'b11, 7'h0, good[i][4], 2'b00, good[i][3:0]};
      expSt.push_back(stExp(good[i], tgt));
      launch(ctl, 1'b1);
      wr(CT, ctl & 16'h7fff);
      rd(CT, ctl);
      while (cpuStall !== 1'b0) @(posedge mclk);
      rd(CT, ctl & 16'h7fff);
      cmpIrq(1'b1);
      wr(ST, 16'h0001);
      cmpIrq(1'b0);
    end
    foreach (nop[i]) begin
      ctl = {2'b11, 7'h0, nop[i][4], 2'b00, nop[i][3:0]};
      launch(ctl, 1'b1);
      rd(CT, ctl & 16'h7fff);
    end
    wr(MK, 16'h0002);
    for (int k = 0; k < 3; k++) begin
      if (k == 2) begin
        wr(KY, 16'h0055);
        wr(MK, 16'h0002);
        wr(KY, 16'h00aa);
      end
      launch(k == 1 ? 16'h8003 : 16'hc003, k == 1);
      rd(CT, k == 1 ? 16'h2003 : 16'h6003);
    end
    cmpIrq(1'b1);
    rd(ST, 16'h0002, 16'h0002);
    wr(ST, 16'h0003);
    cmpIrq(1'b0);
    tgt = nextRand();
    targetAddr <= tgt;
    expSt.push_back(stExp(5'h03, tgt));
    launch(16'hc003, 1'b1);
    launch(16'hc003, 1'b1);
    abortOp <= 1'b1;
    while (cpuStall !== 1'b0) @(posedge mclk);
    abortOp <= 1'b0;
    rd(CT, 16'h6003);
    reset <= 1'b1;
    @(posedge mclk);
    reset <= 1'b0;
    rd(CT, 16'h6003);
    porReset <= 1'b1;
    @(posedge mclk);
    porReset <= 1'b0;
    rd(CT, 16'h0);
    repeat (2) @(negedge mclk);
    if (expSt.size() != 0) fail("strobe missing");
    end_of_test();
  end
endmodule // tb
`default_nettype wire
